/* rtl/mbp_pkg.sv */
// mbp_pkg: constants and carrier types for the host-bus port block
// assumes one clock domain; configuration arrives as fixed straps
package mbp_pkg;
  // ********************************
  // widths, reset value and all-pins pin-function patterns
  // ********************************
  localparam int MBP_PORT_W = 8;
  localparam int MBP_PC_W = 3;
  localparam int MBP_HADDR_W = 8;
  localparam logic [7:0] MBP_RST_BYTE = 8'h00;
  localparam logic [7:0] MBP_PORTB_CS_ALL = 8'h00;
  localparam logic [7:0] MBP_PORTA_ADDR_ALL = 8'hFF;
  localparam logic [2:0] MBP_PORTC_CS_ALL = 3'h7;

  // configuration straps, loaded once at programming
  typedef struct packed {
    logic bus_multiplex_select;
    logic latch_strobe_polarity;
    logic memory_space_split;
    logic porta_track_select;
    logic [7:0] porta_pin_function;
    logic [7:0] portb_pin_function;
    logic [2:0] portc_pin_function;
    logic [7:0] porta_drive_type;
    logic [7:0] portb_drive_type;
  } mbp_cfg_t;

  // decoder terms supplied by the address decoder array
  typedef struct packed {
    logic [7:0] fetch_cs;
    logic [7:0] data_cs;
    logic [2:0] fetch_pc_cs;
    logic [2:0] data_pc_cs;
  } mbp_dec_t;

  // one pin group: output value and enable
  typedef struct packed {
    logic [7:0] val;
    logic [7:0] oe;
  } mbp_pins_t;
endpackage : mbp_pkg

/* rtl/mbp_port.sv */
// mbp_port: address latch, port A/B/C pin function and drive logic
// assumes the host strobes and bus are synchronous to clk_in and the
// decoder array computes chip-select terms from the host address
// assumes the pad ring turns each value/enable pair into a three-state or open-drain pin
// assumes cfg_in never moves while nrst_in is high
`timescale 1ns/1ps
module mbp_port
  import mbp_pkg::*;
#(
  parameter int PORT_W = MBP_PORT_W
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire mbp_cfg_t cfg_in,
  input wire mbp_dec_t dec_in,
  input wire logic [7:0] ad_in,
  input wire logic [MBP_HADDR_W-1:0] high_addr_in,
  input wire logic address_strobe_input_in,
  input wire logic program_fetch_strobe_n_in,
  input wire logic second_host_active_in,
  input wire logic [7:0] porta_gpio_in,
  input wire logic [7:0] portb_gpio_in,
  input wire logic [2:0] portc_pin_in,
  output logic [7:0] porta_out,
  output logic [7:0] porta_oe_out,
  output logic [7:0] portb_out,
  output logic [7:0] portb_oe_out,
  output logic [2:0] portc_out,
  output logic [2:0] portc_oe_out,
  output logic [7:0] latched_addr_out,
  output logic [2:0] portc_addr_out
);
  // ********************************
  // state
  // ********************************
  typedef struct packed {
    logic [7:0] alatch;
    mbp_pins_t pa;
    mbp_pins_t pb;
    logic [2:0] pc_val;
    logic [2:0] pc_oe;
    logic [2:0] pc_addr;
  } mbp_state_t;

  mbp_state_t state_reg;
  mbp_state_t state_next;
  logic strobe_act;
  logic fetch_cyc;
  logic [7:0] cs_sel;
  logic [2:0] pc_cs_sel;

  // ********************************
  // combinational helpers
  // ********************************
  // strobe level follows the programmed polarity
  assign strobe_act = address_strobe_input_in ^ cfg_in.latch_strobe_polarity;
  // fetch cycles only distinguished in split memory mode
  assign fetch_cyc = cfg_in.memory_space_split & ~program_fetch_strobe_n_in;
  assign cs_sel = fetch_cyc ? dec_in.fetch_cs : dec_in.data_cs;
  assign pc_cs_sel = fetch_cyc ? dec_in.fetch_pc_cs : dec_in.data_pc_cs;

  // ********************************
  // next state
  // ********************************
  // cfg_in is a strap input with no write path; the block never alters it
  always_comb begin
    state_next = state_reg;
    // transparent while strobe active, holds after it falls: a latch in clocked form
    if (cfg_in.bus_multiplex_select && strobe_act) begin
      state_next.alatch = ad_in;
    end
    // port A: track has priority and ignores the pin-function field
    if (cfg_in.porta_track_select) begin
      state_next.pa.val = ad_in;
      // released while the second host owns the memory to avoid contention
      state_next.pa.oe = second_host_active_in ? 8'h00 : 8'hFF;
    end else begin
      for (int i = 0; i < PORT_W; i++) begin
        // function bit set: address out, clear: general output
        state_next.pa.val[i] = cfg_in.porta_pin_function[i] ? state_reg.alatch[i]
                                                            : porta_gpio_in[i];
        // open drain leaves ones to the pull-up, so only zeros are driven
        state_next.pa.oe[i] = cfg_in.porta_drive_type[i] ? ~state_next.pa.val[i] : 1'h1;
      end
    end
    // port B: bit clear selects decoder chip-select; identity, latch-enable and
    // bus-width terms are all decoder outputs so they share this path
    for (int i = 0; i < PORT_W; i++) begin
      state_next.pb.val[i] = cfg_in.portb_pin_function[i] ? portb_gpio_in[i]
                                                          : cs_sel[i];
      // open drain only pulls low; a sharing host must also be open drain
      state_next.pb.oe[i] = cfg_in.portb_drive_type[i] ? ~state_next.pb.val[i] : 1'h1;
    end
    // port C: set bit gives chip-select output, clear gives high-address input
    state_next.pc_val = pc_cs_sel & cfg_in.portc_pin_function;
    state_next.pc_oe = cfg_in.portc_pin_function;
    // clear bits read the pin as a high-address input; chip-select bits read back zero
    state_next.pc_addr = portc_pin_in & ~cfg_in.portc_pin_function;
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // every pin value and enable is a flop output, so no strap or bus glitch reaches a pad
  assign porta_out = state_reg.pa.val;
  assign porta_oe_out = state_reg.pa.oe;
  assign portb_out = state_reg.pb.val;
  assign portb_oe_out = state_reg.pb.oe;
  assign portc_out = state_reg.pc_val;
  assign portc_oe_out = state_reg.pc_oe;
  assign latched_addr_out = state_reg.alatch;
  // high_addr_in passes to memory outside the block and is never latched here
  assign portc_addr_out = state_reg.pc_addr;

  // ********************************
  // checks
  // ********************************
  // every check is disabled while nrst_in is low
  // a strobe in multiplexed mode loads the bus byte on that edge
  addr_latch_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (cfg_in.bus_multiplex_select && strobe_act) |=> latched_addr_out == $past(ad_in))
    else $error("address latch missed strobe");
  // without a strobe the latch keeps its byte
  latch_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!strobe_act && $stable(cfg_in)) |=> $stable(latched_addr_out))
    else $error("address latch changed without strobe");

  // address function shows the latch one edge later
  porta_addr_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!cfg_in.porta_track_select && cfg_in.porta_pin_function == MBP_PORTA_ADDR_ALL)
    |=> porta_out == $past(latched_addr_out))
    else $error("port A not showing latched address");
  // track mode without a second host passes the bus and drives every pin
  track_pass_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (cfg_in.porta_track_select && !second_host_active_in)
    |=> porta_out == $past(ad_in) && porta_oe_out == 8'hFF)
    else $error("track mode not passing bus");
  // in track mode a second host on the memory sees port A released
  track_float_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (cfg_in.porta_track_select && second_host_active_in) |=> porta_oe_out == 8'h00)
    else $error("port A driven during second host access");

  // chip-select function carries the selected decoder set
  portb_cs_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (cfg_in.portb_pin_function == MBP_PORTB_CS_ALL) |=> portb_out == $past(cs_sel))
    else $error("port B not showing chip-selects");

  // port C chip-select pins are all driven
  portc_cs_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (cfg_in.portc_pin_function == MBP_PORTC_CS_ALL)
    |=> portc_oe_out == 3'h7 && portc_out == $past(pc_cs_sel))
    else $error("port C not chip-select outputs");
  // a fetch in split mode uses the fetch decoder set
  fetch_split_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (cfg_in.memory_space_split && !program_fetch_strobe_n_in
     && cfg_in.portb_pin_function == MBP_PORTB_CS_ALL)
    |=> portb_out == $past(dec_in.fetch_cs))
    else $error("fetch decode not used");
  // open-drain port B never drives a one
  od_drive_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (cfg_in.portb_drive_type == 8'hFF) |=> (portb_oe_out & portb_out) == 8'h00)
    else $error("open drain pin driving high");

  // a non-multiplexed host never loads the latch
  latch_refuse_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!cfg_in.bus_multiplex_select) |=> $stable(latched_addr_out))
    else $error("address latch loaded in non-multiplexed mode");

  // general output function on port A shows the output value, not the latch
  porta_gpio_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!cfg_in.porta_track_select && cfg_in.porta_pin_function == 8'h00)
    |=> porta_out == $past(porta_gpio_in))
    else $error("port A general output wrong");
  // open-drain port A drives only zeros outside track mode
  porta_od_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!cfg_in.porta_track_select && cfg_in.porta_drive_type == 8'hFF)
    |=> (porta_oe_out & porta_out) == 8'h00)
    else $error("open drain port A pin driving high");

  // data accesses and combined memory use the data decoder set
  data_decode_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!(cfg_in.memory_space_split && !program_fetch_strobe_n_in)
     && cfg_in.portb_pin_function == MBP_PORTB_CS_ALL)
    |=> portb_out == $past(dec_in.data_cs))
    else $error("data decode not used");
  // push-pull port B drives every pin
  portb_cmos_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (cfg_in.portb_drive_type == 8'h00) |=> portb_oe_out == 8'hFF)
    else $error("push-pull port B pin released");
  // general output function on port B shows the output value
  portb_gpio_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (cfg_in.portb_pin_function == 8'hFF) |=> portb_out == $past(portb_gpio_in))
    else $error("port B general output wrong");

  // input function on port C releases the pins and registers their levels
  portc_input_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (cfg_in.portc_pin_function == 3'h0)
    |=> portc_oe_out == 3'h0 && portc_addr_out == $past(portc_pin_in))
    else $error("port C input function wrong");
endmodule : mbp_port

/* bench/mbp_host.sv */
// mbp_host: host side model driving the multiplexed bus and strobes
// assumes the bench calls put; lines change only at falling clock edges
`timescale 1ns/1ps
module mbp_host (
  input wire logic clk_in,
  output logic [7:0] ad_out,
  output logic strobe_out,
  output logic own_out,
  output logic fetch_n_out
);
  initial begin
    ad_out = 8'h00;
    strobe_out = 1'h0;
    own_out = 1'h0;
    fetch_n_out = 1'h1;
  end
  // one bus phase held two cycles; the host always drives its own bus, so lines hold
  task automatic put(input logic [7:0] a, input logic s, input logic o, input logic f);
    @(negedge clk_in);
    ad_out = a;
    strobe_out = s;
    own_out = o;
    fetch_n_out = f;
    repeat (2) @(negedge clk_in);
  endtask : put
endmodule : mbp_host

/* bench/mbp_port_config_test.sv */
// mbp_port_config_test: self-checking bench for the host-bus port block
// assumes straps change only while reset is held
`timescale 1ns/1ps
module mbp_port_config_test;
  import mbp_pkg::*;
  logic clk_in = 1'h0;
  logic nrst_in = 1'h0;
  mbp_cfg_t cfg = '0;
  mbp_dec_t dec = '0;
  logic [7:0] ad, pa, pa_oe, pb, pb_oe, lat;
  logic [2:0] pc, pc_oe;
  logic stb, own, fch_n;
  logic [7:0] pa_gpio = 8'h00;
  logic [7:0] pb_gpio = 8'h00;
  logic [2:0] pc_pin = 3'h0;
  logic [2:0] pc_addr;
  int err_total = 0;
  int cmp_count = 0;
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  mbp_host u_host (.clk_in(clk_in), .ad_out(ad), .strobe_out(stb), .own_out(own),
    .fetch_n_out(fch_n));
  mbp_port u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .cfg_in(cfg), .dec_in(dec),
    .ad_in(ad), .high_addr_in(8'h00), .address_strobe_input_in(stb),
    .program_fetch_strobe_n_in(fch_n), .second_host_active_in(own),
    .porta_gpio_in(pa_gpio), .portb_gpio_in(pb_gpio), .portc_pin_in(pc_pin),
    .porta_out(pa), .porta_oe_out(pa_oe), .portb_out(pb), .portb_oe_out(pb_oe),
    .portc_out(pc), .portc_oe_out(pc_oe), .latched_addr_out(lat), .portc_addr_out(pc_addr));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // straps are only touched under reset, never in operation
  task automatic base();
    @(negedge clk_in);
    nrst_in = 1'h0;
    cfg = '0;
    cfg.bus_multiplex_select = 1'h1;
    cfg.porta_pin_function = MBP_PORTA_ADDR_ALL;
    cfg.portc_pin_function = MBP_PORTC_CS_ALL;
  endtask : base
  task automatic go();
    repeat (2) @(negedge clk_in);
    chk({pa_oe, pb_oe}, 16'h0000);
    nrst_in = 1'h1;
  endtask : go
  task automatic t_latch();
    base();
    go();
    u_host.put(8'h5A, 1'h1, 1'h0, 1'h1);
    chk({lat, pa}, 16'h5A5A);
    u_host.put(8'hA5, 1'h0, 1'h0, 1'h1);
    chk({lat, pa_oe}, 16'h5AFF);
    base();
    cfg.bus_multiplex_select = 1'h0;
    go();
    u_host.put(8'h3C, 1'h1, 1'h0, 1'h1);
    chk({8'h00, lat}, 16'h0000);
    base();
    cfg.latch_strobe_polarity = 1'h1;
    go();
    u_host.put(8'h96, 1'h0, 1'h0, 1'h1);
    chk({8'h00, lat}, 16'h0096);
    $display("test latch done");
  endtask : t_latch
  task automatic t_track();
    base();
    cfg.porta_track_select = 1'h1;
    cfg.porta_pin_function = 8'h00;
    go();
    u_host.put(8'hC3, 1'h1, 1'h0, 1'h1);
    chk({pa, pa_oe}, 16'hC3FF);
    u_host.put(8'h3C, 1'h1, 1'h1, 1'h1);
    chk({8'h00, pa_oe}, 16'h0000);
    $display("test track done");
  endtask : t_track
  task automatic t_selects();
    base();
    go();
    dec = '{fetch_cs: 8'h3C, data_cs: 8'hA5, fetch_pc_cs: 3'h2, data_pc_cs: 3'h5};
    u_host.put(8'h00, 1'h0, 1'h0, 1'h1);
    chk({pb, pb_oe}, 16'hA5FF);
    chk({5'h00, pc, 5'h00, pc_oe}, 16'h0507);
    base();
    cfg.memory_space_split = 1'h1;
    go();
    u_host.put(8'h00, 1'h0, 1'h0, 1'h0);
    chk({pb, 5'h00, pc}, 16'h3C02);
    u_host.put(8'h00, 1'h0, 1'h0, 1'h1);
    chk({pb, 5'h00, pc}, 16'hA505);
    base();
    cfg.portb_drive_type = 8'hFF;
    go();
    u_host.put(8'h00, 1'h0, 1'h0, 1'h1);
    chk({pb, pb_oe}, 16'hA55A);
    $display("test selects done");
  endtask : t_selects
  task automatic t_gpio();
    base();
    cfg.porta_pin_function = 8'h00;
    cfg.porta_drive_type = 8'hFF;
    cfg.portb_pin_function = 8'hFF;
    cfg.portc_pin_function = 3'h0;
    go();
    pa_gpio = 8'h69;
    pb_gpio = 8'h1E;
    pc_pin = 3'h6;
    u_host.put(8'hFF, 1'h1, 1'h0, 1'h1);
    chk({pa, pa_oe}, 16'h6996);
    chk({pb, pb_oe}, 16'h1EFF);
    chk({2'h0, pc, pc_oe, 5'h00, pc_addr}, 16'h0006);
    chk({lat, 8'h00}, 16'hFF00);
    $display("test gpio done");
  endtask : t_gpio
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (16) @(negedge clk_in);
    t_latch();
    t_track();
    t_selects();
    t_gpio();
    give_verdict();
  end
endmodule : mbp_port_config_test
